// ### rtl/tbt_bit_rise.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// rising edge detector on a selected time base bit
// ------------------------------------------------------------
module tbt_bit_rise (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // time base
  tbt_tick_if.dst tb_if,
  // bit position and pulse
  input wire logic [5:0] i_pos,
  output logic o_rise
);
  import tbt_pkg::*;
  logic prev_reg;
  logic prev_next;
  logic cur;

  // select bit, remember last value
  always_comb begin
    cur = tb_if.tb[i_pos];
    prev_next = prev_reg;
    if (tb_if.tick) begin
      prev_next = cur;
    end
  end
  assign o_rise = tb_if.tick && cur && !prev_reg;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end
endmodule

// ### rtl/tbt_pkg.sv
package tbt_pkg;
  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int TB_W = 64;
  localparam int CD_W = 32;
  localparam logic [63:0] TB_RST = 64'h0000_0000_0000_0000;
  localparam logic [31:0] CD_RST = 32'h0000_0000;
  // selectable time base bit positions, periodic timer
  localparam logic [5:0] PB_BIT0 = 6'h09;
  localparam logic [5:0] PB_BIT1 = 6'h0D;
  localparam logic [5:0] PB_BIT2 = 6'h11;
  localparam logic [5:0] PB_BIT3 = 6'h15;
  // selectable time base bit positions, watchdog
  localparam logic [5:0] WD_BIT0 = 6'h11;
  localparam logic [5:0] WD_BIT1 = 6'h15;
  localparam logic [5:0] WD_BIT2 = 6'h19;
  localparam logic [5:0] WD_BIT3 = 6'h1D;
  // reset type codes
  localparam logic [1:0] RST_NONE = 2'h0;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {WD_IDLE, WD_ONE, WD_FIRED} tbt_wd_state_t;
endpackage

// ### rtl/tbt_tick_if.sv
`timescale 1ns/1ps
// tick and time base shared between top and edge detector
interface tbt_tick_if;
  logic tick;
  logic [63:0] tb;
  modport src (output tick, output tb);
  modport dst (input tick, input tb);
endinterface

// ### rtl/tbt_timers.sv
`timescale 1ns/1ps
module tbt_timers (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // time base source
  input wire logic i_ext_sel,
  input wire logic i_ext_tick,
  // countdown control
  input wire logic i_cd_wr,
  input wire logic [31:0] i_cd_wdata,
  input wire logic i_cd_reload_en,
  input wire logic i_cd_clr,
  // periodic timer control
  input wire logic [1:0] i_pb_sel,
  input wire logic i_pb_clr,
  // watchdog control
  input wire logic [1:0] i_wd_sel,
  input wire logic [1:0] i_wd_rst_type,
  input wire logic i_wd_en,
  input wire logic i_wd_clr,
  // state and events
  output logic [63:0] o_tb,
  output logic [31:0] o_cd,
  output logic o_cd_irq,
  output logic o_pb_irq,
  output logic o_wd_irq,
  output logic o_wd_rst,
  output logic [1:0] o_wd_rst_type
);
  import tbt_pkg::*;

  // ------------------------------------------------------------
  // tick selection and time base
  // ------------------------------------------------------------
  tbt_tick_if tick_if ();
  logic tick;
  logic [63:0] tb_reg, tb_next;

  function automatic logic [5:0] pb_pos(input logic [1:0] s);
    case (s)
      2'h0: pb_pos = PB_BIT0;
      2'h1: pb_pos = PB_BIT1;
      2'h2: pb_pos = PB_BIT2;
      default: pb_pos = PB_BIT3;
    endcase
  endfunction

  function automatic logic [5:0] wd_pos(input logic [1:0] s);
    case (s)
      2'h0: wd_pos = WD_BIT0;
      2'h1: wd_pos = WD_BIT1;
      2'h2: wd_pos = WD_BIT2;
      default: wd_pos = WD_BIT3;
    endcase
  endfunction

  // cpu clock rate or external tick
  assign tick = i_ext_sel ? i_ext_tick : 1'b1;
  assign tick_if.tick = tick;
  assign tick_if.tb = tb_reg;

  // time base next value, wrap is silent
  always_comb begin
    tb_next = tb_reg;
    if (tick) begin
      tb_next = tb_reg + 64'h0000_0000_0000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tb_reg <= TB_RST;
    end else begin
      tb_reg <= tb_next;
    end
  end

  // ------------------------------------------------------------
  // countdown timer
  // ------------------------------------------------------------
  logic [31:0] cd_reg, cd_next, cd_load_reg, cd_load_next;
  logic cd_irq_reg, cd_irq_next;

  // load, decrement, reload or hold
  always_comb begin
    cd_next = cd_reg;
    cd_load_next = cd_load_reg;
    cd_irq_next = cd_irq_reg && !i_cd_clr;
    if (i_cd_wr) begin
      cd_next = i_cd_wdata;
      cd_load_next = i_cd_wdata;
    end else if (tick && cd_reg != CD_RST) begin
      cd_next = cd_reg - 32'h0000_0001;
      if (cd_reg == 32'h0000_0001) begin
        cd_irq_next = 1'b1;
        if (i_cd_reload_en) begin
          cd_next = cd_load_reg;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cd_reg <= CD_RST;
      cd_load_reg <= CD_RST;
      cd_irq_reg <= 1'b0;
    end else begin
      cd_reg <= cd_next;
      cd_load_reg <= cd_load_next;
      cd_irq_reg <= cd_irq_next;
    end
  end

  // ------------------------------------------------------------
  // periodic bit timer
  // ------------------------------------------------------------
  logic pb_rise;
  logic pb_irq_reg, pb_irq_next;

  tbt_bit_rise u_pb_rise (
    .i_clk (i_clk),
    .i_nrst (i_nrst),
    .tb_if (tick_if.dst),
    .i_pos (pb_pos(i_pb_sel)),
    .o_rise (pb_rise)
  );

  // sticky flag, set wins over clear
  always_comb begin
    pb_irq_next = (pb_irq_reg && !i_pb_clr) || pb_rise;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pb_irq_reg <= 1'b0;
    end else begin
      pb_irq_reg <= pb_irq_next;
    end
  end

  // ------------------------------------------------------------
  // watchdog timer
  // ------------------------------------------------------------
  logic wd_rise;
  tbt_wd_state_t wd_reg, wd_next;
  logic wd_irq_reg, wd_irq_next;
  logic wd_rst_reg, wd_rst_next;
  logic [1:0] wd_type_reg, wd_type_next;

  tbt_bit_rise u_wd_rise (
    .i_clk (i_clk),
    .i_nrst (i_nrst),
    .tb_if (tick_if.dst),
    .i_pos (wd_pos(i_wd_sel)),
    .o_rise (wd_rise)
  );

  // interval count: one, then second unserviced fires reset
  always_comb begin
    wd_next = wd_reg;
    wd_irq_next = wd_irq_reg;
    wd_rst_next = 1'b0;
    wd_type_next = wd_type_reg;
    if (i_wd_clr) begin
      wd_irq_next = 1'b0;
      if (wd_reg != WD_FIRED) begin
        wd_next = WD_IDLE;
      end
    end
    if (wd_rise) begin
      wd_irq_next = 1'b1;
      case (wd_reg)
        WD_IDLE: begin
          wd_next = WD_ONE;
        end
        WD_ONE: begin
          if (!i_wd_clr && i_wd_en) begin
            wd_next = WD_FIRED;
            wd_rst_next = (i_wd_rst_type != RST_NONE);
            wd_type_next = i_wd_rst_type;
          end else begin
            wd_next = WD_ONE;
          end
        end
        WD_FIRED: begin
          wd_next = WD_FIRED;
        end
        default: begin
          wd_next = WD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wd_reg <= WD_IDLE;
      wd_irq_reg <= 1'b0;
      wd_rst_reg <= 1'b0;
      wd_type_reg <= RST_NONE;
    end else begin
      wd_reg <= wd_next;
      wd_irq_reg <= wd_irq_next;
      wd_rst_reg <= wd_rst_next;
      wd_type_reg <= wd_type_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_tb = tb_reg;
  assign o_cd = cd_reg;
  assign o_cd_irq = cd_irq_reg;
  assign o_pb_irq = pb_irq_reg;
  assign o_wd_irq = wd_irq_reg;
  assign o_wd_rst = wd_rst_reg;
  assign o_wd_rst_type = wd_type_reg;
endmodule

// ### sim/tb_tbt_timers.sv
`timescale 1ns/1ps
module tb_tbt_timers;
  import tbt_pkg::*;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_ext_sel = 1'b0, i_ext_tick = 1'b0;
  logic i_cd_wr = 1'b0, i_cd_reload_en = 1'b0, i_cd_clr = 1'b0;
  logic i_pb_clr = 1'b0, wd_clr, o_cd_irq, o_pb_irq, o_wd_irq, o_wd_rst;
  logic [31:0] i_cd_wdata = 32'h0, o_cd;
  logic [63:0] o_tb, t;
  logic [1:0] i_pb_sel = 2'h0, wd_type;
  int error_cnt = 0, n_tests = 0;
  typedef struct {logic [31:0] w; logic r; int n; logic [31:0] c; logic f;}
    tbt_row_t;
  // load value, reload, ticks, expected count, expected flag
  tbt_row_t rows[7] = '{'{32'h3, 1'b0, 3, 32'h0, 1'b1},
    '{32'h3, 1'b0, 6, 32'h0, 1'b1}, '{32'h5, 1'b0, 2, 32'h3, 1'b0},
    '{32'hFFFF_FFFF, 1'b0, 1, 32'hFFFF_FFFE, 1'b0},
    '{32'h2, 1'b1, 2, 32'h2, 1'b1}, '{32'h2, 1'b1, 3, 32'h1, 1'b1},
    '{32'h0, 1'b0, 4, 32'h0, 1'b0}};
  // clock
  always #20 i_clk = ~i_clk;
  tbt_timers u_tbt_timers (.i_clk, .i_nrst, .i_ext_sel, .i_ext_tick,
    .i_cd_wr, .i_cd_wdata, .i_cd_reload_en, .i_cd_clr, .i_pb_sel,
    .i_pb_clr, .i_wd_sel(2'h0), .i_wd_rst_type(2'h1), .i_wd_en(1'b1),
    .i_wd_clr(wd_clr), .o_tb, .o_cd, .o_cd_irq, .o_pb_irq, .o_wd_irq,
    .o_wd_rst, .o_wd_rst_type(wd_type));
  tbt_core_model u_tbt_core_model (.i_clk, .i_svc(1'b1), .i_wd_irq(o_wd_irq),
    .o_wd_clr(wd_clr));
  // compare and count
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(negedge i_clk);
    chk("rst_tb", 64'h0, o_tb);
    chk("rst_cd", 32'h0, o_cd);
    i_nrst = 1'b1;
    @(negedge i_clk);
    chk("tb_first", 64'h1, o_tb);
    foreach (rows[i]) begin
      i_cd_wdata = rows[i].w;
      i_cd_reload_en = rows[i].r;
      i_cd_wr = 1'b1;
      i_cd_clr = 1'b1;
      @(negedge i_clk);
      i_cd_wr = 1'b0;
      i_cd_clr = 1'b0;
      repeat (rows[i].n) @(negedge i_clk);
      chk("cd", rows[i].c, o_cd);
      chk("cd_irq", rows[i].f, o_cd_irq);
      $display("row %0d done", i);
    end
    i_ext_sel = 1'b1;
    i_cd_wdata = 32'h9;
    i_cd_wr = 1'b1;
    @(negedge i_clk);
    i_cd_wr = 1'b0;
    t = o_tb;
    repeat (4) @(negedge i_clk);
    chk("tb_hold", t, o_tb);
    chk("cd_hold", 32'h9, o_cd);
    i_ext_tick = 1'b1;
    @(negedge i_clk);
    i_ext_tick = 1'b0;
    chk("tb_ext", t + 64'h1, o_tb);
    chk("cd_ext", 32'h8, o_cd);
    i_ext_sel = 1'b0;
    $display("ext tick done");
    repeat (600) if (o_tb !== 64'h1FF) @(negedge i_clk);
    chk("pb_early", 1'b0, o_pb_irq);
    repeat (2) @(negedge i_clk);
    chk("pb_rise", 1'b1, o_pb_irq);
    i_pb_clr = 1'b1;
    @(negedge i_clk);
    i_pb_clr = 1'b0;
    repeat (600) if (o_tb !== 64'h406) @(negedge i_clk);
    chk("pb_fall", 1'b0, o_pb_irq);
    chk("wd_rst", 1'b0, o_wd_rst);
    $display("periodic done");
    // second bit position: only bit 13 may raise the flag now
    i_pb_sel = 2'h1;
    repeat (8000) if (o_tb !== 64'h1FFF) @(negedge i_clk);
    chk("pb1_early", 1'b0, o_pb_irq);
    repeat (2) @(negedge i_clk);
    chk("pb1_rise", 1'b1, o_pb_irq);
    // watchdog bit not yet reached: no interrupt, no reset type
    chk("wd_irq", 1'b0, o_wd_irq);
    chk("wd_type", RST_NONE, wd_type);
    $display("select done");
    end_sim();
  end
  // hang guard
  initial begin
    #600us;
    error_cnt++;
    $display("[FAIL] run exp done got hang");
    end_sim();
  end
endmodule

// ### sim/tbt_core_model.sv
`timescale 1ns/1ps
module tbt_core_model (
  input wire logic i_clk,
  input wire logic i_svc,
  input wire logic i_wd_irq,
  output logic o_wd_clr
);
  initial o_wd_clr = 1'b0;
  // handler services a watchdog interrupt with a one-cycle clear
  always @(negedge i_clk) begin
    o_wd_clr <= i_svc && i_wd_irq && !o_wd_clr;
  end
endmodule

// ### sim/tbt_timers_monitor.sv
`timescale 1ns/1ps
module tbt_timers_monitor (
  input wire logic i_clk, i_nrst, i_ext_sel, i_ext_tick,
  input wire logic i_cd_wr, i_cd_reload_en, i_cd_clr, i_pb_clr,
  input wire logic [31:0] i_cd_wdata,
  input wire logic [63:0] o_tb,
  input wire logic [31:0] o_cd,
  input wire logic o_cd_irq, o_pb_irq, o_wd_rst
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // tick as the block sees it
  wire logic tk = i_ext_sel ? i_ext_tick : 1'b1;
  // last countdown step before zero
  sequence s_last;
    tk && !i_cd_wr && o_cd == 32'h0000_0001;
  endsequence
  a_tb_step: assert property (tk |=> o_tb == $past(o_tb) + 64'h1)
    else $error("tb step");
  a_tb_hold: assert property (!tk |=> $stable(o_tb))
    else $error("tb hold");
  a_cd_load: assert property (i_cd_wr |=> o_cd == $past(i_cd_wdata))
    else $error("cd load");
  a_cd_step: assert property (tk && !i_cd_wr && o_cd > 32'h1
    |=> o_cd == $past(o_cd) - 32'h1) else $error("cd step");
  a_cd_fire: assert property (s_last |=> o_cd_irq)
    else $error("cd fire");
  a_cd_park: assert property (s_last ##0 !i_cd_reload_en |=> o_cd == 0)
    else $error("cd park");
  a_cd_keep: assert property (o_cd_irq && !i_cd_clr |=> o_cd_irq)
    else $error("cd keep");
  a_pb_keep: assert property (o_pb_irq && !i_pb_clr |=> o_pb_irq)
    else $error("pb keep");
  a_wd_pulse: assert property (o_wd_rst |=> !o_wd_rst [*8])
    else $error("wd pulse");
endmodule
bind tbt_timers tbt_timers_monitor u_mon (.i_clk, .i_nrst, .i_ext_sel,
  .i_ext_tick, .i_cd_wr, .i_cd_reload_en, .i_cd_clr, .i_pb_clr, .i_cd_wdata,
  .o_tb, .o_cd, .o_cd_irq, .o_pb_irq, .o_wd_rst);
